/* File: common/rpp_params.svh */
// Constants of the real-power-to-pulse datapath.
`ifndef RPP_PARAMS_SVH
`define RPP_PARAMS_SVH
`define RPP_CLK_HZ          50000000
`define RPP_DATA_W          16
`define RPP_PROD_W          40
`define RPP_LPF_SHIFT       19
`define RPP_HPF_SHIFT       10
`define RPP_PHC_SHIFT       11
`define RPP_EPULSE_W_CYC    16'h0400
`define RPP_CF_W_CYC        16'h0010
`define RPP_CF_RATIO_LOG2   7
`define RPP_RATE_BASE_LOG2  21
`define RPP_THR_EXTRA_LOG2  20
`define RPP_ENERGY_W        48
`define RPP_FIFO_DEPTH      16
`endif

/* File: common/rpp_pkg.sv */
// Types of the real-power-to-pulse datapath.
package rpp_pkg;
    typedef logic signed [15:0] rpp_sample_t;
    typedef enum logic [1:0] {
        RPP_GAIN_1  = 2'b00,
        RPP_GAIN_2  = 2'b01,
        RPP_GAIN_8  = 2'b10,
        RPP_GAIN_16 = 2'b11
    } rpp_gain_e;
    typedef enum logic [0:0] {
        RPP_SEL_PRIMARY   = 1'b0,
        RPP_SEL_SECONDARY = 1'b1
    } rpp_sel_e;
endpackage

/* File: design/rpp_fifo.sv */
// Sample FIFO held in flip-flops, with valid and ready on both sides.
`timescale 1ns/1ps
module rpp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    logic [AW:0]      next_count;

    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        end
    end

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Ready is registered from the next fill level so that the port comes from a flop.
    // It stays low while the datapath is held in reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count    <= '0;
            in_ready <= 1'b0;
        end else begin
            count    <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule

/* File: design/rpp_datapath.sv */
// Real-power-to-pulse datapath: gain, channel select, filters, multiplier, pulse outputs.
`timescale 1ns/1ps
`include "rpp_params.svh"
module rpp_datapath #(
    parameter int FIFO_DEPTH = `RPP_FIFO_DEPTH,
    parameter int RATE_LOG2  = `RPP_RATE_BASE_LOG2
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                supply_ok,
    // Converter samples
    input  wire logic                sample_valid,
    output logic                     sample_ready,
    input  wire rpp_pkg::rpp_sample_t primary_current_input,
    input  wire rpp_pkg::rpp_sample_t secondary_current_input,
    input  wire rpp_pkg::rpp_sample_t voltage_input,
    // Configuration pins
    input  wire logic                gain_select_lo,
    input  wire logic                gain_select_hi,
    input  wire logic                highpass_enable_pin,
    input  wire logic                rate_select_lo,
    input  wire logic                rate_select_hi,
    input  wire logic                use_secondary,
    // Pulse outputs and active-input flag
    output logic                     energy_pulse_a,
    output logic                     energy_pulse_b,
    output logic                     calibration_pulse_out,
    output logic                     active_is_secondary
);
    import rpp_pkg::*;

    // ------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;
    logic [2:0] sup_sync;
    logic       sup_ok;
    logic       run_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_sync <= 3'h0;
        end else begin
            sup_sync <= {sup_sync[1:0], supply_ok};
        end
    end

    // supply filter: supply status changes only when stages agree.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sup_ok <= 1'b0;
        end else if (sup_sync[2] == sup_sync[1]) begin
            sup_ok <= sup_sync[2];
        end
    end
    assign run_n = rst_n && sup_ok;

    // Configuration pins are static straps, synchronised the same way.
    logic [5:0] cfg_s1;
    logic [5:0] cfg_s2;
    logic [5:0] cfg_s3;
    logic [5:0] cfg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_s1 <= 6'h00;
            cfg_s2 <= 6'h00;
            cfg_s3 <= 6'h00;
        end else begin
            cfg_s1 <= {use_secondary, rate_select_hi, rate_select_lo,
                       highpass_enable_pin, gain_select_hi, gain_select_lo};
            cfg_s2 <= cfg_s1;
            cfg_s3 <= cfg_s2;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= 6'h00;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (cfg_s3[i] == cfg_s2[i]) begin
                    cfg[i] <= cfg_s3[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Sample FIFO and channel select
    // ------------------------------------------------------------
    logic        f_valid;
    logic [47:0] f_data;
    rpp_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (run_n),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   ({primary_current_input, secondary_current_input, voltage_input}),
        .out_valid (f_valid),
        .out_ready (1'b1),
        .out_data  (f_data)
    );

    rpp_sel_e    sel;
    rpp_sample_t cur;
    logic signed [20:0] cur_g;

    // primary after reset. single active input.
    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            sel <= RPP_SEL_PRIMARY;
        end else if (f_valid) begin
            sel <= cfg[5] ? RPP_SEL_SECONDARY : RPP_SEL_PRIMARY;
        end
    end
    assign cur = (sel == RPP_SEL_SECONDARY) ? f_data[31:16] : f_data[47:32];

    always_comb begin
        case (rpp_gain_e'(cfg[1:0]))
            RPP_GAIN_1:  cur_g = 21'(cur);
            RPP_GAIN_2:  cur_g = 21'(cur) <<< 1;
            RPP_GAIN_8:  cur_g = 21'(cur) <<< 3;
            default:     cur_g = 21'(cur) <<< 4;
        endcase
    end

    // ------------------------------------------------------------
    // High-pass filter and phase compensation
    // ------------------------------------------------------------
    logic signed [36:0] hp_acc;
    logic signed [20:0] hp_out;
    logic signed [20:0] ph_out;
    logic signed [36:0] ph_acc;
    logic signed [20:0] v_d;

    // dc tracker subtracted from the current.
    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            hp_acc <= '0;
        end else if (f_valid && cfg[2]) begin
            hp_acc <= hp_acc + 37'(hp_out);
        end
    end
    assign hp_out = cur_g - 21'(hp_acc >>> `RPP_HPF_SHIFT);

    // voltage gets a matching lead so the channels stay aligned.
    // The compensation is a first-order lead network on voltage; its error grows
    // slowly with frequency, small across the dc to 1 kHz band.
    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            ph_acc <= '0;
        end else if (f_valid && cfg[2]) begin
            ph_acc <= ph_acc + 37'(ph_out);
        end
    end
    assign v_d    = 21'($signed(f_data[15:0]));
    assign ph_out = cfg[2] ? v_d - 21'(ph_acc >>> `RPP_PHC_SHIFT) : v_d;

    // ------------------------------------------------------------
    // Multiplier and low-pass filter
    // ------------------------------------------------------------
    logic signed [41:0] prod;
    logic signed [63:0] lp_acc;
    logic signed [41:0] power;
    logic               p_valid;

    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            prod    <= '0;
            p_valid <= 1'b0;
        end else begin
            prod    <= (cfg[2] ? hp_out : cur_g) * ph_out;
            p_valid <= f_valid;
        end
    end

    // first-order low-pass; shift sets the corner near 8.9 Hz at sample rate.
    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            lp_acc <= '0;
        end else if (p_valid) begin
            lp_acc <= lp_acc + 64'(prod) - 64'(power);
        end
    end
    assign power = 42'(lp_acc >>> `RPP_LPF_SHIFT);

    // ------------------------------------------------------------
    // Digital-to-frequency conversion
    // ------------------------------------------------------------
    logic signed [63:0] acc_e;
    logic signed [63:0] acc_c;
    logic [63:0]        thr_e;
    logic [63:0]        thr_c;
    logic [15:0]        wid_e;
    logic [15:0]        wid_c;
    logic               phase_b;
    logic [5:0]         shift_e;

    // rate select shortens the long threshold by one bit per code step.
    assign shift_e = 6'(RATE_LOG2) + 6'(`RPP_THR_EXTRA_LOG2) - 6'({cfg[4], cfg[3]});
    // long period. calibration 128 times shorter.
    assign thr_e = 64'h1 << shift_e;
    assign thr_c = thr_e >> `RPP_CF_RATIO_LOG2;

    logic               fire_e;
    logic               fire_c;
    logic signed [63:0] sum_e;
    logic signed [63:0] sum_c;

    // A threshold is taken off only when a pulse can start. While a pulse still runs
    // the energy waits in the accumulator, so a burst is paid out later, not lost.
    assign sum_e  = acc_e + 64'(power);
    assign sum_c  = acc_c + 64'(power);
    assign fire_e = p_valid && (wid_e == 16'h0000) && ($signed(thr_e) <= sum_e);
    assign fire_c = p_valid && (wid_c == 16'h0000) && ($signed(thr_c) <= sum_c);

    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            acc_e <= '0;
        end else if (fire_e) begin
            acc_e <= sum_e - $signed(thr_e);
        end else if (p_valid) begin
            acc_e <= (sum_e < 0) ? '0 : sum_e;
        end
    end

    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            acc_c <= '0;
        end else if (fire_c) begin
            acc_c <= sum_c - $signed(thr_c);
        end else if (p_valid) begin
            acc_c <= (sum_c < 0) ? '0 : sum_c;
        end
    end

    // fixed pulse width counters; active-low energy outputs alternate.
    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            wid_e   <= 16'h0000;
            phase_b <= 1'b0;
        end else if (fire_e) begin
            wid_e   <= `RPP_EPULSE_W_CYC;
            phase_b <= ~phase_b;
        end else if (wid_e != 16'h0000) begin
            wid_e <= wid_e - 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            wid_c <= 16'h0000;
        end else if (fire_c) begin
            wid_c <= `RPP_CF_W_CYC;
        end else if (wid_c != 16'h0000) begin
            wid_c <= wid_c - 16'h0001;
        end
    end

    // outputs idle while held in reset.
    always_ff @(posedge clk or negedge run_n) begin
        if (!run_n) begin
            energy_pulse_a        <= 1'b1;
            energy_pulse_b        <= 1'b1;
            calibration_pulse_out <= 1'b1;
            active_is_secondary   <= 1'b0;
        end else begin
            energy_pulse_a        <= !(wid_e != 16'h0000 && phase_b);
            energy_pulse_b        <= !(wid_e != 16'h0000 && !phase_b);
            calibration_pulse_out <= !(wid_c != 16'h0000);
            active_is_secondary   <= (sel == RPP_SEL_SECONDARY);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    quiet_reset_a: assert property (@(posedge clk) !run_n |=> energy_pulse_a)
        else $error("energy pulse during reset");
    pulse_width_a: assert property (@(posedge clk) disable iff (!run_n)
        $fell(energy_pulse_a) |-> ##1 !energy_pulse_a [*8])
        else $error("energy pulse too short");
    lows_excl_a: assert property (@(posedge clk) disable iff (!run_n)
        !(!energy_pulse_a && !energy_pulse_b))
        else $error("both energy outputs low");
    sel_follow_a: assert property (@(posedge clk) disable iff (!run_n)
        f_valid && !cfg[5] |=> sel == RPP_SEL_PRIMARY)
        else $error("wrong current input");
    hp_bypass_a: assert property (@(posedge clk) disable iff (!run_n)
        !cfg[2] |-> ph_out == v_d)
        else $error("phase stage active with filter off");
    hp_frozen_a: assert property (@(posedge clk) disable iff (!run_n)
        !cfg[2] |=> $stable(hp_acc) && $stable(ph_acc))
        else $error("filter state moved while bypassed");
    cf_ratio_a: assert property (@(posedge clk) disable iff (!run_n)
        thr_e == (thr_c << 7))
        else $error("calibration ratio wrong");
    rate_shift_a: assert property (@(posedge clk) disable iff (!run_n)
        cfg[4:3] == 2'h3 |-> shift_e == 6'(RATE_LOG2) + 6'd17)
        else $error("rate select wrong");
    start_primary_a: assert property (@(posedge clk) $rose(run_n) |-> sel == RPP_SEL_PRIMARY)
        else $error("secondary active after reset");
    cf_pulse_c: cover property (@(posedge clk) disable iff (!run_n) $fell(calibration_pulse_out));
    ea_pulse_c: cover property (@(posedge clk) disable iff (!run_n) $fell(energy_pulse_a));
    eb_pulse_c: cover property (@(posedge clk) disable iff (!run_n) $fell(energy_pulse_b));
endmodule

/* File: testbench/rpp_pulse_counter.sv */
// Pulse counter model standing at the far side of the pulse outputs.
`timescale 1ns/1ps
`include "rpp_params.svh"
module rpp_pulse_counter #(
    parameter int EP_W = `RPP_EPULSE_W_CYC,
    parameter int CF_W = `RPP_CF_W_CYC
) (
    // Clock and tally clear
    input  wire logic   clk,
    input  wire logic   clear,
    // Pulse lines watched
    input  wire logic   energy_pulse_a,
    input  wire logic   energy_pulse_b,
    input  wire logic   calibration_pulse_out,
    // Tallies
    output logic [31:0] cnt_a,
    output logic [31:0] cnt_b,
    output logic [31:0] cnt_cf,
    output logic [31:0] bad_width,
    output logic [31:0] bad_order
);
    logic [31:0] low_a;
    logic [31:0] low_b;
    logic [31:0] low_cf;
    logic [2:0]  prev;
    logic [2:0]  now_v;
    logic [2:0]  fell;
    logic [2:0]  rose;
    logic [2:0]  wrong_w;
    logic [1:0]  last;
    logic        wrong_o;

    // --------------------------------------------------------------
    // Edge detection
    // --------------------------------------------------------------
    assign now_v = {calibration_pulse_out, energy_pulse_b, energy_pulse_a};
    assign fell  = prev & ~now_v;
    assign rose  = ~prev & now_v;
    assign wrong_w = {rose[2] && low_cf != CF_W, rose[1] && low_b != EP_W,
                      rose[0] && low_a != EP_W};
    // Both energy lines low at once would stall a two-phase stepper.
    assign wrong_o = (fell[0] && last == 2'd1) || (fell[1] && last == 2'd2)
                     || (now_v[1:0] == 2'b00);

    // --------------------------------------------------------------
    // Tallies
    // --------------------------------------------------------------
    // totals, low-time counters and the last energy line that fell
    always_ff @(posedge clk) begin
        if (clear) begin
            prev      <= 3'h7;
            last      <= 2'd0;
            low_a     <= 32'h0;
            low_b     <= 32'h0;
            low_cf    <= 32'h0;
            cnt_a     <= 32'h0;
            cnt_b     <= 32'h0;
            cnt_cf    <= 32'h0;
            bad_width <= 32'h0;
            bad_order <= 32'h0;
        end else begin
            prev      <= now_v;
            low_a     <= rose[0] ? 32'h0 : low_a + 32'(!now_v[0]);
            low_b     <= rose[1] ? 32'h0 : low_b + 32'(!now_v[1]);
            low_cf    <= rose[2] ? 32'h0 : low_cf + 32'(!now_v[2]);
            cnt_a     <= cnt_a + 32'(fell[0]);
            cnt_b     <= cnt_b + 32'(fell[1]);
            cnt_cf    <= cnt_cf + 32'(fell[2]);
            bad_width <= bad_width + 32'(wrong_w[0]) + 32'(wrong_w[1]) + 32'(wrong_w[2]);
            bad_order <= bad_order + 32'(wrong_o);
            if (fell[0]) begin
                last <= 2'd1;
            end else if (fell[1]) begin
                last <= 2'd2;
            end
        end
    end
endmodule

/* File: testbench/test_real_power_to_pulse_datapath.sv */
// Self-checking bench for the real-power-to-pulse datapath.
`timescale 1ns/1ps
`define RPP_CHECK(what, got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("mismatch %s expected %0d seen %0d", what, exp, got); \
        end \
    end
module test_real_power_to_pulse_datapath;
    import rpp_pkg::*;
    localparam int RATE_LOG2 = 2;
    localparam int WIN       = 8000;
    logic        clk;
    logic        nrst;
    logic        supply_ok;
    logic        sample_valid;
    logic        sample_ready;
    rpp_sample_t cur_p;
    rpp_sample_t cur_s;
    rpp_sample_t volt;
    logic [1:0]  gain;
    logic [1:0]  rate;
    logic        hpf;
    logic        use_sec;
    logic        pulse_a;
    logic        pulse_b;
    logic        pulse_cf;
    logic        active_sec;
    logic        clear;
    logic [31:0] cnt_a;
    logic [31:0] cnt_b;
    logic [31:0] cnt_cf;
    logic [31:0] bad_width;
    logic [31:0] bad_order;
    logic [31:0] e_cnt [4];
    logic [31:0] c_cnt [4];
    logic [31:0] cf_plain;
    int          n_mismatch;
    int          n_checks;

    rpp_datapath #(.RATE_LOG2(RATE_LOG2)) dut_u (
        .clk(clk), .nrst(nrst), .supply_ok(supply_ok),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .primary_current_input(cur_p), .secondary_current_input(cur_s),
        .voltage_input(volt), .gain_select_lo(gain[0]), .gain_select_hi(gain[1]),
        .highpass_enable_pin(hpf), .rate_select_lo(rate[0]), .rate_select_hi(rate[1]),
        .use_secondary(use_sec), .energy_pulse_a(pulse_a), .energy_pulse_b(pulse_b),
        .calibration_pulse_out(pulse_cf), .active_is_secondary(active_sec));

    rpp_pulse_counter pc_u (
        .clk(clk), .clear(clear), .energy_pulse_a(pulse_a), .energy_pulse_b(pulse_b),
        .calibration_pulse_out(pulse_cf), .cnt_a(cnt_a), .cnt_b(cnt_b), .cnt_cf(cnt_cf),
        .bad_width(bad_width), .bad_order(bad_order));

    // --------------------------------------------------------------
    // Clock, reset and run control
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Strap pins are set while reset is held, so every run starts from empty filters.
    task automatic start(input rpp_sample_t p, input rpp_sample_t s, input rpp_sample_t v,
                         input logic [1:0] g, input logic [1:0] r, input logic h,
                         input logic sec, input logic sup);
        @(posedge clk);
        nrst      <= 1'b0;
        clear     <= 1'b1;
        cur_p     <= p;
        cur_s     <= s;
        volt      <= v;
        gain      <= g;
        rate      <= r;
        hpf       <= h;
        use_sec   <= sec;
        supply_ok <= sup;
        repeat (3) @(posedge clk);
        nrst  <= 1'b1;
        clear <= 1'b0;
    endtask

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        int i;
        n_mismatch   = 0;
        n_checks     = 0;
        nrst         = 1'b0;
        clear        = 1'b1;
        supply_ok    = 1'b1;
        sample_valid = 1'b1;
        cur_p        = 16'h0000;
        cur_s        = 16'h0000;
        volt         = 16'h0000;
        gain         = 2'b00;
        rate         = 2'b00;
        hpf          = 1'b0;
        use_sec      = 1'b0;
        start(16'h0000, 16'h4000, 16'h4000, 2'b11, 2'b11, 1'b0, 1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        `RPP_CHECK("idle energy a", pulse_a, 1'b1)
        `RPP_CHECK("idle energy b", pulse_b, 1'b1)
        `RPP_CHECK("idle calibration", pulse_cf, 1'b1)
        `RPP_CHECK("input after reset", active_sec, 1'b0)
        repeat (4000) @(posedge clk);
        `RPP_CHECK("pulses from idle input", cnt_a + cnt_b + cnt_cf, 32'h0)
        `RPP_CHECK("sample ready", sample_ready, 1'b1)
        $display("test primary_default done");
        start(16'h0000, 16'h4000, 16'h4000, 2'b11, 2'b11, 1'b0, 1'b1, 1'b1);
        for (i = 0; i < 20 && active_sec !== 1'b1; i++) begin
            @(posedge clk);
        end
        if (i == 20) begin
            n_mismatch++;
            $display("mismatch active_is_secondary expected 1 seen %b", active_sec);
            finish_test();
        end
        repeat (4000) @(posedge clk);
        `RPP_CHECK("secondary drives power", cnt_cf > 0, 1'b1)
        $display("test secondary_select done");
        for (i = 0; i < 4; i++) begin
            start(16'h0080, 16'h0000, 16'h0080, 2'b00, i[1:0], 1'b0, 1'b0, 1'b1);
            repeat (WIN) @(posedge clk);
            e_cnt[i] = cnt_a + cnt_b;
            c_cnt[i] = cnt_cf;
            if (i > 0) `RPP_CHECK("energy rate order", e_cnt[i] >= e_cnt[i-1], 1'b1)
        end
        `RPP_CHECK("fastest over slowest rate", e_cnt[3] > e_cnt[0], 1'b1)
        `RPP_CHECK("energy pulses present", e_cnt[3] > 0, 1'b1)
        `RPP_CHECK("calibration faster", c_cnt[3] > e_cnt[3], 1'b1)
        `RPP_CHECK("energy slower at code 0", c_cnt[0] > e_cnt[0], 1'b1)
        cf_plain = c_cnt[3];
        $display("test rate_select done");
        start(16'h0080, 16'h0000, 16'h0080, 2'b00, 2'b11, 1'b1, 1'b0, 1'b1);
        repeat (WIN) @(posedge clk);
        `RPP_CHECK("dc removed by high-pass", cnt_cf < cf_plain, 1'b1)
        $display("test highpass done");
        for (i = 0; i < 4; i++) begin
            start(16'h0040, 16'h0000, 16'h0040, i[1:0], 2'b11, 1'b0, 1'b0, 1'b1);
            repeat (WIN) @(posedge clk);
            c_cnt[i] = cnt_cf;
            if (i > 0) `RPP_CHECK("gain order", c_cnt[i] >= c_cnt[i-1], 1'b1)
        end
        `RPP_CHECK("gain 16 over gain 1", c_cnt[3] > c_cnt[0], 1'b1)
        $display("test gain_select done");
        start(16'h0400, 16'h0000, 16'h0400, 2'b11, 2'b11, 1'b0, 1'b0, 1'b0);
        repeat (2000) @(posedge clk);
        `RPP_CHECK("pulses on low supply", cnt_a + cnt_b + cnt_cf, 32'h0)
        `RPP_CHECK("ready on low supply", sample_ready, 1'b0)
        supply_ok <= 1'b1;
        repeat (4000) @(posedge clk);
        `RPP_CHECK("pulses after supply good", cnt_cf > 0, 1'b1)
        `RPP_CHECK("pulse widths", bad_width, 32'h0)
        `RPP_CHECK("energy line order", bad_order, 32'h0)
        supply_ok <= 1'b0;
        repeat (8) @(posedge clk);
        cf_plain = cnt_a + cnt_b + cnt_cf;
        repeat (1000) @(posedge clk);
        `RPP_CHECK("pulses after supply loss", cnt_a + cnt_b + cnt_cf, cf_plain)
        `RPP_CHECK("calibration idle on supply loss", pulse_cf, 1'b1)
        $display("test supply_monitor done");
        finish_test();
    end
endmodule
